/* src/dac_device_end.sv */
// converter digital front end: frame shifter, input and converter
// registers, control register, readback, load strobe, clear and alarm.
// assumes every link pin is asynchronous to core_clk_i; the serial clock
// must stay well below a quarter of the core clock rate.
`timescale 1ns/1ps
module dac_device_end
(
  input wire logic core_clk_i, // 125 MHz core clock
  input wire logic rst_i, // synchronous reset, active high
  dac_link_if.device link, // serial link pins
  input wire logic over_temp_i, // die sensor, high above threshold
  input wire logic range_sel_i, // range strap, low for wide span
  output logic [dac_link_pkg::NCH-1:0][dac_link_pkg::DATA_W-1:0] dac_code_o, // converter codes
  output logic [dac_link_pkg::NCH-1:0] chan_on_o, // channel powered up
  output logic pd_to_ground_o, // powered-down outputs tied to ground
  output logic range_wide_o, // wide output span selected
  output logic frame_done_o // pulse: a frame was taken
);
  import dac_link_pkg::*;

  // synchroniser bit positions
  localparam int P_SCLK = 0;
  localparam int P_SYNC = 1;
  localparam int P_SDI = 2;
  localparam int P_LOAD = 3;
  localparam int P_CLR = 4;
  localparam int P_HOT = 5;
  localparam int P_RSEL = 6;
  localparam int NP = 7;
  // idle levels: sync, load, clear and range strap high, the rest low, so
  // no false edge or span flash follows reset
  localparam logic [NP-1:0] PIN_IDLE = 7'h5A;

  typedef enum {F_IDLE, F_SHIFT, F_WAIT} frame_state_t;

  logic [NP-1:0] meta_reg;
  logic [NP-1:0] pin_reg;
  logic [NP-1:0] prev_reg;
  logic sclk_rise, sclk_fall, sync_fall, sync_rise, load_fall, clr_fall;
  logic clr_low, load_low, hot;
  frame_state_t fst_reg;
  logic [FRAME_BITS-1:0] shift_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [NCH-1:0][DATA_W-1:0] in_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] rd_reg;
  logic commit;
  logic is_read;
  logic [2:0] addr;
  logic [DATA_W-1:0] rd_word;

  // map a frame address to a readback word
  function automatic logic [DATA_W-1:0] read_word(input logic [2:0] a,
    input logic [NCH-1:0][DATA_W-1:0] codes, input logic [CTRL_W-1:0] c);
    logic [DATA_W-1:0] w;
    w = ZERO_CODE;
    if (a == ADDR_CTRL)
      w = {{(DATA_W-CTRL_W){1'b0}}, c};
    else if (a >= ADDR_DAC_FIRST && a <= ADDR_DAC_LAST)
      w = codes[2'(a - ADDR_DAC_FIRST)];
    return w;
  endfunction

  // two flops on every pin plus a third for edges; the first stage feeds no logic
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= PIN_IDLE;
      pin_reg <= PIN_IDLE;
      prev_reg <= PIN_IDLE;
    end
    else
    begin
      meta_reg <= {range_sel_i, over_temp_i, link.async_clear_in_n,
        link.load_strobe_n, link.sdi, link.sync_n, link.sclk};
      pin_reg <= meta_reg;
      prev_reg <= pin_reg;
    end
  end

  // edge and level decode of the synchronised pins
  assign sclk_rise = pin_reg[P_SCLK] & ~prev_reg[P_SCLK];
  assign sclk_fall = ~pin_reg[P_SCLK] & prev_reg[P_SCLK];
  assign sync_fall = ~pin_reg[P_SYNC] & prev_reg[P_SYNC];
  assign sync_rise = pin_reg[P_SYNC] & ~prev_reg[P_SYNC];
  assign load_fall = ~pin_reg[P_LOAD] & prev_reg[P_LOAD];
  assign clr_fall = ~pin_reg[P_CLR] & prev_reg[P_CLR];
  assign clr_low = ~pin_reg[P_CLR];
  assign load_low = ~pin_reg[P_LOAD];
  assign hot = pin_reg[P_HOT];

  // frame complete: sixteenth falling sclk with frame-sync still low
  assign commit = (fst_reg == F_SHIFT) && sclk_fall && !sync_rise
    && cnt_reg == CNT_W'(FRAME_BITS);
  assign is_read = shift_reg[RD_FLAG_BIT];
  assign addr = shift_reg[ADDR_MSB:ADDR_LSB];
  // readback word chosen as the fourth command bit arrives
  assign rd_word = read_word({shift_reg[1:0], pin_reg[P_SDI]}, dac_code_o, ctrl_reg);

  // frame sequencer; an early frame-sync rise drops the partial word
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      fst_reg <= F_IDLE;
      cnt_reg <= '0;
    end
    else
    begin
      case (fst_reg)
        F_IDLE:
        begin
          if (sync_fall)
          begin
            fst_reg <= F_SHIFT;
            cnt_reg <= '0;
          end
        end
        F_SHIFT:
        begin
          if (sync_rise)
            fst_reg <= F_IDLE;
          else if (commit)
            fst_reg <= F_WAIT;
          else if (sclk_rise && cnt_reg != CNT_W'(FRAME_BITS))
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
        F_WAIT:
        begin
          // extra clocks after the word are ignored until frame-sync rises
          if (sync_rise)
            fst_reg <= F_IDLE;
        end
        default: fst_reg <= F_IDLE;
      endcase
    end
  end

  // sixteen-bit shifter, msb first, sampled on rising sclk
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      shift_reg <= '0;
    else if (fst_reg == F_SHIFT && sclk_rise && cnt_reg != CNT_W'(FRAME_BITS))
      shift_reg <= {shift_reg[FRAME_BITS-2:0], pin_reg[P_SDI]};
  end

  // input registers: written by a completed write frame, zeroed by clear
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      in_reg <= {NCH{ZERO_CODE}};
    else if (clr_fall)
      in_reg <= {NCH{ZERO_CODE}};
    else if (commit && !is_read && addr >= ADDR_DAC_FIRST && addr <= ADDR_DAC_LAST)
      in_reg[2'(addr - ADDR_DAC_FIRST)] <= shift_reg[DATA_W-1:0];
  end

  // converter registers: loaded on a strobe edge, or at frame end while
  // the strobe is held low; clear always wins
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      dac_code_o <= {NCH{ZERO_CODE}};
    else if (clr_fall)
      dac_code_o <= {NCH{ZERO_CODE}};
    else if (load_fall && !clr_low)
      dac_code_o <= in_reg;
    else if (load_low && !clr_low && commit && !is_read
      && addr >= ADDR_DAC_FIRST && addr <= ADDR_DAC_LAST)
      dac_code_o[2'(addr - ADDR_DAC_FIRST)] <= shift_reg[DATA_W-1:0];
  end

  // control register; over-temperature drops all power bits and they
  // stay down until a control write sets them again
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      ctrl_reg <= CTRL_RESET;
    else if (hot)
      ctrl_reg[CTRL_PWR_MSB:CTRL_PWR_LSB] <= '0;
    else if (commit && !is_read && addr == ADDR_CTRL)
      ctrl_reg <= shift_reg[CTRL_W-1:0];
  end

  // readback: once the command nibble is in, the word leaves msb first,
  // one bit per rising sclk, so the host can sample on the falling edge
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rd_reg <= ZERO_CODE;
      link.sdo <= 1'b0;
    end
    else if (fst_reg == F_SHIFT && sclk_rise && cnt_reg == CNT_W'(CMD_BITS - 1)
      && shift_reg[CMD_BITS-2])
    begin
      // shift_reg holds three command bits; the fourth arrives now
      rd_reg <= rd_word;
      link.sdo <= rd_word[DATA_W-1];
    end
    else if (fst_reg == F_SHIFT && sclk_rise && cnt_reg >= CNT_W'(CMD_BITS)
      && cnt_reg < CNT_W'(FRAME_BITS - 1))
    begin
      rd_reg <= {rd_reg[DATA_W-2:0], 1'b0};
      link.sdo <= rd_reg[DATA_W-2];
    end
    else if (fst_reg == F_IDLE)
      link.sdo <= 1'b0;
  end

  // status outputs, all registered
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      link.alarm_n <= 1'b1;
      // status mirrors the control reset value while reset is held
      chan_on_o <= CTRL_RESET[CTRL_PWR_MSB:CTRL_PWR_LSB];
      pd_to_ground_o <= CTRL_RESET[CTRL_PD_MODE];
      range_wide_o <= 1'b0;
      frame_done_o <= 1'b0;
    end
    else
    begin
      link.alarm_n <= ~hot;
      chan_on_o <= ctrl_reg[CTRL_PWR_MSB:CTRL_PWR_LSB];
      pd_to_ground_o <= ctrl_reg[CTRL_PD_MODE];
      range_wide_o <= ~pin_reg[P_RSEL];
      frame_done_o <= commit;
    end
  end
endmodule

/* src/dac_host_end.sv */
// serial host for the converter link: turns one request at a time into
// a sixteen-bit frame, pulses the load strobe and the clear line.
// assumes requests come from logic on core_clk_i; sdo and alarm are pins.
`timescale 1ns/1ps
module dac_host_end
(
  input wire logic core_clk_i, // 125 MHz core clock
  input wire logic rst_i, // synchronous reset, active high
  dac_link_if.host link, // serial link pins
  input wire logic req_valid_i, // frame request
  input wire logic req_read_i, // 1: readback frame
  input wire logic [2:0] req_addr_i, // register address
  input wire logic [dac_link_pkg::DATA_W-1:0] req_data_i, // write data
  input wire logic load_i, // pulse: one load strobe pulse
  input wire logic hold_load_i, // level: keep load strobe low
  input wire logic clear_i, // pulse: one clear pulse
  output logic ready_o, // idle, request may be given
  output logic done_o, // pulse: frame finished
  output logic [dac_link_pkg::DATA_W-1:0] rd_data_o, // readback word
  output logic alarm_o // over-temperature seen on the link
);
  import dac_link_pkg::*;

  typedef enum {H_IDLE, H_SETUP, H_BITS, H_END, H_GAP} host_state_t;

  host_state_t hst_reg;
  logic [TMR_W-1:0] tmr_reg;
  logic [FRAME_BITS-1:0] tx_reg;
  logic [CNT_W-1:0] fall_reg;
  logic [1:0] sdo_sync_reg;
  logic [1:0] alarm_sync_reg;
  logic [TMR_W-1:0] load_tmr_reg;
  logic [TMR_W-1:0] clr_tmr_reg;
  logic tick;

  // half-period divider; the serial clock is made here, not sampled
  assign tick = (tmr_reg == TMR_W'(SCLK_HALF_CYC - 1));

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || hst_reg == H_IDLE || tick)
      tmr_reg <= '0;
    else
      tmr_reg <= tmr_reg + TMR_W'(1);
  end

  // sdo and alarm come from the other chip: two flops each
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      sdo_sync_reg <= '0;
      alarm_sync_reg <= 2'h3;
      alarm_o <= 1'b0;
    end
    else
    begin
      sdo_sync_reg <= {sdo_sync_reg[0], link.sdo};
      alarm_sync_reg <= {alarm_sync_reg[0], link.alarm_n};
      alarm_o <= ~alarm_sync_reg[1];
    end
  end

  // frame sequencer: data goes out on falling sclk for a rising capture,
  // readback is sampled on falling sclk
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      hst_reg <= H_IDLE;
      link.sclk <= 1'b0;
      link.sync_n <= 1'b1;
      link.sdi <= 1'b0;
      tx_reg <= '0;
      fall_reg <= '0;
      ready_o <= 1'b1;
      done_o <= 1'b0;
      rd_data_o <= ZERO_CODE;
    end
    else
    begin
      done_o <= 1'b0;
      case (hst_reg)
        H_IDLE:
        begin
          if (req_valid_i)
          begin
            tx_reg <= {req_read_i, req_addr_i, req_data_i};
            link.sdi <= req_read_i;
            link.sync_n <= 1'b0;
            fall_reg <= '0;
            ready_o <= 1'b0;
            hst_reg <= H_SETUP;
          end
        end
        H_SETUP:
        begin
          if (tick)
            hst_reg <= H_BITS;
        end
        H_BITS:
        begin
          if (tick && !link.sclk)
            link.sclk <= 1'b1;
          else if (tick)
          begin
            link.sclk <= 1'b0;
            // falls 4 to 15 carry the readback word
            if (fall_reg >= CNT_W'(CMD_BITS - 1) && fall_reg < CNT_W'(FRAME_BITS - 1))
              rd_data_o <= {rd_data_o[DATA_W-2:0], sdo_sync_reg[1]};
            tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
            link.sdi <= tx_reg[FRAME_BITS-2];
            fall_reg <= fall_reg + CNT_W'(1);
            if (fall_reg == CNT_W'(FRAME_BITS - 1))
              hst_reg <= H_END;
          end
        end
        H_END:
        begin
          // frame-sync rises only after the sixteenth fall, never aborting
          if (tick)
          begin
            link.sync_n <= 1'b1;
            hst_reg <= H_GAP;
          end
        end
        H_GAP:
        begin
          if (tick)
          begin
            ready_o <= 1'b1;
            done_o <= 1'b1;
            hst_reg <= H_IDLE;
          end
        end
        default: hst_reg <= H_IDLE;
      endcase
    end
  end

  // load strobe: either held low or pulsed for a fixed width
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      load_tmr_reg <= '0;
      link.load_strobe_n <= 1'b1;
    end
    else
    begin
      if (load_i)
        load_tmr_reg <= TMR_W'(LOAD_LOW_CYC);
      else if (load_tmr_reg != '0)
        load_tmr_reg <= load_tmr_reg - TMR_W'(1);
      link.load_strobe_n <= ~(hold_load_i || load_i || load_tmr_reg > TMR_W'(1));
    end
  end

  // clear pulse of fixed width
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      clr_tmr_reg <= '0;
      link.async_clear_in_n <= 1'b1;
    end
    else
    begin
      if (clear_i)
        clr_tmr_reg <= TMR_W'(CLEAR_LOW_CYC);
      else if (clr_tmr_reg != '0)
        clr_tmr_reg <= clr_tmr_reg - TMR_W'(1);
      link.async_clear_in_n <= ~(clear_i || clr_tmr_reg > TMR_W'(1));
    end
  end
endmodule

/* src/dac_link_if.sv */
// pins between the serial host and the converter's digital front end.
// all lines are point to point, one driver each; no tri-state.
`timescale 1ns/1ps
interface dac_link_if;
  logic sclk;
  logic sync_n;
  logic sdi;
  logic sdo;
  logic load_strobe_n;
  logic async_clear_in_n;
  logic alarm_n;

  modport device (
    input sclk, sync_n, sdi, load_strobe_n, async_clear_in_n,
    output sdo, alarm_n
  );
  modport host (
    output sclk, sync_n, sdi, load_strobe_n, async_clear_in_n,
    input sdo, alarm_n
  );
endinterface

/* src/dac_link_pkg.sv */
// shared constants for the quad converter serial link: frame layout,
// register map, reset values and timing counts.
// assumes a 125 MHz core clock on both ends.
package dac_link_pkg;
  // frame layout: bit 15 read flag, bits 14:12 address, bits 11:0 data
  localparam int FRAME_BITS = 16;
  localparam int CMD_BITS = 4;
  localparam int DATA_W = 12;
  localparam int NCH = 4;
  localparam int CTRL_W = 7;
  localparam int CNT_W = 5;
  localparam int RD_FLAG_BIT = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 12;
  localparam logic [2:0] ADDR_DAC_FIRST = 3'h1;
  localparam logic [2:0] ADDR_DAC_LAST = 3'h4;
  localparam logic [2:0] ADDR_CTRL = 3'h7;
  // control register fields and reset value (analog section powered down)
  localparam int CTRL_PWR_LSB = 2;
  localparam int CTRL_PWR_MSB = 5;
  localparam int CTRL_PD_MODE = 6;
  localparam logic [6:0] CTRL_RESET = 7'h40;
  localparam logic [11:0] ZERO_CODE = 12'h000;
  // timing
  localparam int CORE_PERIOD_NS = 8;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SYNC_HIGH_NS = 20;
  localparam int LOAD_LOW_NS = 20;
  localparam int CLEAR_LOW_NS = 15;

  // least time in ns to whole core cycles, never below two (the far end
  // samples through two flops and must see every level)
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    return (c < 2) ? 2 : c;
  endfunction

  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / 2 / CORE_PERIOD_NS;
  localparam int SYNC_HIGH_CYC = min_cycles(SYNC_HIGH_NS);
  localparam int LOAD_LOW_CYC = min_cycles(LOAD_LOW_NS);
  localparam int CLEAR_LOW_CYC = min_cycles(CLEAR_LOW_NS);
  localparam int TMR_W = 4;
endpackage

/* test/dac_link_props.sv */
// pin-level checks on the converter link between the two design ends.
// assumes the host end drives the link pins and core_clk_i samples them.
`timescale 1ns/1ps
module dac_link_props
(
  input wire logic core_clk_i, // core clock
  input wire logic rst_i, // synchronous reset
  input wire logic sclk, // serial clock
  input wire logic sync_n, // frame sync
  input wire logic sdi, // serial data in
  input wire logic sdo, // readback data
  input wire logic load_strobe_n, // load strobe
  input wire logic async_clear_in_n // clear line
);
  logic sclk_reg;
  logic [4:0] rise_reg;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // count sclk rises in a frame; a frame that is cut short shows a low count
  always_ff @(posedge core_clk_i)
  begin
    sclk_reg <= sclk;
    if (rst_i || sync_n)
      rise_reg <= 5'h00;
    else if (sclk && !sclk_reg)
      rise_reg <= rise_reg + 5'h01;
  end

  sclk_idle_a: assert property (sync_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  sync_setup_a: assert property ($fell(sync_n) |-> !sclk [*8])
    else $error("first clock rise too soon after frame start");
  sclk_high_a: assert property ($rose(sclk) |-> sclk [*8])
    else $error("serial clock high phase too short");
  sclk_low_a: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("serial clock low phase too short");
  sdi_hold_a: assert property (!sync_n && $changed(sdi) |-> $fell(sclk) || $fell(sync_n))
    else $error("data in changed away from a falling clock");
  frame_len_a: assert property ($rose(sync_n) |-> rise_reg == 5'h10 && !sclk)
    else $error("frame did not hold sixteen clocks");
  sync_gap_a: assert property ($rose(sync_n) |-> sync_n [*3])
    else $error("frame sync high gap too short");
  sdo_edge_a: assert property (!sync_n && $changed(sdo) |-> sclk)
    else $error("readback data changed while clock low");
  sdo_idle_a: assert property (sync_n [*8] |-> !sdo)
    else $error("readback data not idle between frames");
  load_pulse_a: assert property ($fell(load_strobe_n) |-> !load_strobe_n [*3])
    else $error("load strobe pulse too short");
  clear_pulse_a: assert property ($fell(async_clear_in_n) |-> !async_clear_in_n [*2] ##1 async_clear_in_n)
    else $error("clear pulse length wrong");
endmodule

/* test/quad_dac_serial_update_control_tb_top.sv */
// bench for the converter link: host end and device end face each other;
// a second device end is driven straight from the bench to break framing.
// assumes the design files and the link interface are compiled first.
`timescale 1ns/1ps
module quad_dac_serial_update_control_tb_top;
  import dac_link_pkg::*;
  logic core_clk_i, rst_i, req_valid, req_read, load, hold_load, clear;
  logic ready, done, alarm, over_temp, range_sel, pd_gnd, range_wide;
  logic [2:0] req_addr;
  logic [11:0] req_data, rd_data;
  logic [3:0] chan_on;
  logic fdone;
  int fdone_cnt = 0;
  logic [NCH-1:0][DATA_W-1:0] codes, codes_b;
  logic [11:0] vals [4] = '{12'hFFF, 12'h001, 12'hA5A, 12'h800};
  int error_cnt = 0;
  int checks = 0;
  dac_link_if la();
  dac_link_if lb();

  dac_host_end dac_host_end_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(la),
    .req_valid_i(req_valid), .req_read_i(req_read), .req_addr_i(req_addr),
    .req_data_i(req_data), .load_i(load), .hold_load_i(hold_load), .clear_i(clear),
    .ready_o(ready), .done_o(done), .rd_data_o(rd_data), .alarm_o(alarm));
  dac_device_end dac_device_end_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(la),
    .over_temp_i(over_temp), .range_sel_i(range_sel), .dac_code_o(codes),
    .chan_on_o(chan_on), .pd_to_ground_o(pd_gnd), .range_wide_o(range_wide),
    .frame_done_o(fdone));
  // second device end: its pins come from the bench, not from a host end
  dac_device_end dac_device_end_inst_b (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(lb),
    .over_temp_i(1'b0), .range_sel_i(1'b1), .dac_code_o(codes_b), .chan_on_o(),
    .pd_to_ground_o(), .range_wide_o(), .frame_done_o());
  dac_link_props dac_link_props_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .sclk(la.sclk), .sync_n(la.sync_n), .sdi(la.sdi), .sdo(la.sdo),
    .load_strobe_n(la.load_strobe_n), .async_clear_in_n(la.async_clear_in_n));

  // 125 MHz core clock
  always #4 core_clk_i = ~core_clk_i;

  // committed frames seen on the device side, one per host frame
  always @(posedge core_clk_i)
    if (fdone === 1'b1)
      fdone_cnt++;

  task automatic test_done;
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // one host request; done is looked at on falling edges, clear of the race
  task automatic frame(input logic rd, input logic [2:0] a, input logic [11:0] d);
    int n;
    int f0;
    n = 0;
    f0 = fdone_cnt;
    req_read <= rd;
    req_addr <= a;
    req_data <= d;
    req_valid <= 1'b1;
    @(posedge core_clk_i);
    req_valid <= 1'b0;
    do
    begin
      @(negedge core_clk_i);
      n++;
    end
    while (done !== 1'b1 && n < 600);
    chk(12'(done), 12'h001);
    chk(12'(ready), 12'h001);
    chk(12'(fdone_cnt - f0), 12'h001);
    @(posedge core_clk_i);
  endtask

  task automatic pulse(input logic clr);
    clear <= clr;
    load <= !clr;
    @(posedge core_clk_i);
    clear <= 1'b0;
    load <= 1'b0;
    cyc(12);
  endtask

  // bench-made frame of n bits at a 64 ns serial clock; data in toggles after
  task automatic b_frame(input logic [15:0] w, input int n);
    lb.sync_n <= 1'b0;
    for (int i = 15; i > 15 - n; i--)
    begin
      lb.sdi <= w[i];
      cyc(4);
      lb.sclk <= 1'b1;
      cyc(4);
      lb.sclk <= 1'b0;
    end
    cyc(4);
    lb.sync_n <= 1'b1;
    lb.sdi <= ~lb.sdi;
    cyc(8);
  endtask

  task automatic b_load;
    lb.load_strobe_n <= 1'b0;
    cyc(4);
    lb.load_strobe_n <= 1'b1;
    cyc(8);
  endtask

  task automatic t_reset;
    for (int i = 0; i < NCH; i++)
      chk(codes[i], ZERO_CODE);
    chk(12'(chan_on), 12'h000);
    chk(12'(pd_gnd), 12'h001);
  endtask

  task automatic t_range;
    chk(12'(range_wide), 12'h000);
    range_sel <= 1'b0;
    cyc(8);
    chk(12'(range_wide), 12'h001);
    range_sel <= 1'b1;
    cyc(8);
  endtask

  task automatic t_load;
    for (int i = 0; i < NCH; i++)
      frame(1'b0, 3'(i + 1), vals[i]);
    chk(codes[3], ZERO_CODE);
    pulse(1'b0);
    for (int i = 0; i < NCH; i++)
      chk(codes[i], vals[i]);
  endtask

  task automatic t_read;
    for (int i = 0; i < NCH; i++)
    begin
      frame(1'b1, 3'(i + 1), 12'h000);
      chk(rd_data, vals[i]);
    end
    frame(1'b1, ADDR_CTRL, 12'h000);
    chk(rd_data, {5'h00, CTRL_RESET});
    // an address with no register behind it reads back as zero
    frame(1'b1, 3'h5, 12'h000);
    chk(rd_data, 12'h000);
  endtask

  // hazard must win over an earlier power-up until a fresh control write
  task automatic t_power;
    hold_load <= 1'b1;
    frame(1'b0, 3'h2, 12'h3C3);
    chk(codes[1], 12'h3C3);
    hold_load <= 1'b0;
    frame(1'b0, ADDR_CTRL, 12'h03C);
    chk(12'(chan_on), 12'h00F);
    over_temp <= 1'b1;
    cyc(12);
    chk(12'(alarm), 12'h001);
    over_temp <= 1'b0;
    cyc(12);
    chk(12'(alarm), 12'h000);
    chk(12'(chan_on), 12'h000);
    frame(1'b0, ADDR_CTRL, 12'h03C);
    chk(12'(chan_on), 12'h00F);
  endtask

  task automatic t_clear;
    pulse(1'b1);
    for (int i = 0; i < NCH; i++)
      chk(codes[i], ZERO_CODE);
  endtask

  task automatic t_abort;
    lb.load_strobe_n <= 1'b0;
    b_frame(16'h1777, 16);
    chk(codes_b[0], 12'h777);
    b_frame(16'h1123, 15);
    chk(codes_b[0], 12'h777);
    lb.load_strobe_n <= 1'b1;
    lb.async_clear_in_n <= 1'b0;
    cyc(8);
    chk(codes_b[0], ZERO_CODE);
    b_frame(16'h2456, 16);
    b_load();
    chk(codes_b[1], ZERO_CODE);
    lb.async_clear_in_n <= 1'b1;
    cyc(8);
    b_load();
    chk(codes_b[1], 12'h456);
  endtask

  // main sequence
  initial
  begin
    core_clk_i = 1'b0;
    rst_i = 1'b1;
    {req_valid, req_read, load, hold_load, clear, over_temp} = 6'h00;
    req_addr = 3'h0;
    req_data = 12'h000;
    range_sel = 1'b1;
    {lb.sclk, lb.sdi} = 2'h0;
    {lb.sync_n, lb.load_strobe_n, lb.async_clear_in_n} = 3'h7;
    cyc(6);
    rst_i <= 1'b0;
    cyc(4);
    t_reset();
    t_range();
    t_load();
    t_read();
    t_power();
    t_clear();
    t_abort();
    test_done();
  end

  // watchdog: the whole run needs well under 10,000 core cycles
  initial
  begin
    #200000;
    error_cnt++;
    test_done();
  end
endmodule
